//--- wdg_top.sv
// watchdog timer: timeout control, interrupt and system reset request
`timescale 1ns/10ps
module wdg_top #(
	parameter int unsigned TMO_BASE_EXP = wdg_pkg::TMO_BASE_EXP	// timeout exponent base
) (
	input  wire logic                        CLK_SYS_I,	// bus clock, 100 MHz
	input  wire logic                        NRST_I,	// async reset, active low
	input  wire logic                        WDOG_ENABLE_BIT_I,	// watchdog enable
	input  wire logic                        RESPONSE_MODE_BIT_I,	// 0 reset, 1 interrupt first
	input  wire logic [wdg_pkg::SEL_W-1:0]   TIMEOUT_RANGE_INIT_I,	// first timeout select
	input  wire logic [wdg_pkg::SEL_W-1:0]   TIMEOUT_RANGE_I,	// later timeout select
	input  wire logic [wdg_pkg::LEN_W-1:0]   RESET_PULSE_LEN_FIELD_I,	// pulse length select
	input  wire logic                        RESTART_WR_I,	// restart register write strobe
	input  wire logic [wdg_pkg::KEY_W-1:0]   RESTART_DATA_I,	// restart write data, low byte
	input  wire logic                        IRQ_CLEAR_RD_I,	// clear-on-read register read strobe
	output logic                             SYS_RST_O,	// system reset request, active high
	output logic                             IRQ_O,	// watchdog interrupt, active high
	output logic                             RUNNING_O,	// counter is active
	output logic [wdg_pkg::CNT_W-1:0]        COUNT_O	// current counter value
);

	// ----------------------------------------------------------------
	// timeout decode
	// ----------------------------------------------------------------

	function automatic logic [wdg_pkg::CNT_W-1:0] tmo_value(input logic [wdg_pkg::SEL_W-1:0] sel);
		tmo_value = wdg_pkg::CNT_ONE << (TMO_BASE_EXP + sel);
	endfunction : tmo_value

	// ----------------------------------------------------------------
	// sub blocks
	// ----------------------------------------------------------------

	wdg_core_if core ();

	wdg_down_cnt u_cnt (
		.clk_i  (CLK_SYS_I),
		.nrst_i (NRST_I),
		.core   (core)
	);

	wdg_rst_pulse u_pulse (
		.clk_i  (CLK_SYS_I),
		.nrst_i (NRST_I),
		.core   (core)
	);

	// ----------------------------------------------------------------
	// restart decode and timeout events
	// ----------------------------------------------------------------

	wdg_pkg::wdg_state_t st;
	wdg_pkg::wdg_state_t next_st;
	logic                irq;
	logic                next_irq;
	logic                first_done;
	logic                next_first_done;
	logic                kick;
	logic                timeout;
	logic                to_reset;
	logic                to_irq;

	assign kick = RESTART_WR_I && (RESTART_DATA_I == wdg_pkg::KICK_KEY);

	// a coinciding restart masks the timeout
	assign timeout = (st == wdg_pkg::ST_RUN) && WDOG_ENABLE_BIT_I && core.zero && !kick;

	assign to_reset = timeout && (!RESPONSE_MODE_BIT_I || irq);
	assign to_irq   = timeout && RESPONSE_MODE_BIT_I && !irq;

	// ----------------------------------------------------------------
	// control state machine
	// ----------------------------------------------------------------

	logic                      ld;
	logic [wdg_pkg::CNT_W-1:0] ld_val;
	logic                      run;
	logic                      pls_start;

	// the timeout select is sampled when the enable arrives, so it must be in place first
	always_comb
	begin
		next_st         = st;
		next_first_done = first_done;
		ld              = 1'b0;
		// later loads use the regular field
		ld_val          = tmo_value(TIMEOUT_RANGE_I);
		run             = 1'b0;
		pls_start       = 1'b0;
		case (st)
			wdg_pkg::ST_IDLE:
			begin
				if (WDOG_ENABLE_BIT_I)
				begin
					ld              = 1'b1;
					next_first_done = 1'b1;
					next_st         = wdg_pkg::ST_RUN;
					if (!first_done)
						ld_val = tmo_value(TIMEOUT_RANGE_INIT_I);
				end
			end
			wdg_pkg::ST_RUN:
			begin
				if (!WDOG_ENABLE_BIT_I)
					next_st = wdg_pkg::ST_IDLE;
				else if (kick)
					ld = 1'b1;
				else if (to_reset)
				begin
					pls_start = 1'b1;
					next_st   = wdg_pkg::ST_RST;
				end
				// second window starts right after the interrupt
				else if (to_irq)
					ld = 1'b1;
				else
					run = 1'b1;
			end
			wdg_pkg::ST_RST:
			begin
				if (core.pls_last)
				begin
					ld      = WDOG_ENABLE_BIT_I;
					next_st = WDOG_ENABLE_BIT_I ? wdg_pkg::ST_RUN : wdg_pkg::ST_IDLE;
				end
			end
			default:
			begin
				next_st = wdg_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			st         <= wdg_pkg::ST_IDLE;
			first_done <= 1'b0;
		end
		else
		begin
			st         <= next_st;
			first_done <= next_first_done;
		end
	end

	assign core.load      = ld;
	assign core.load_val  = ld_val;
	assign core.run       = run;
	assign core.pls_start = pls_start;
	assign core.pls_sel   = RESET_PULSE_LEN_FIELD_I;

	// ----------------------------------------------------------------
	// interrupt flag
	// ----------------------------------------------------------------

	// set wins over clear so a timeout landing on a clear is never lost
	always_comb
	begin
		next_irq = irq;
		if (kick || IRQ_CLEAR_RD_I)
			next_irq = 1'b0;
		if (to_irq)
			next_irq = 1'b1;
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I)
	begin
		if (!NRST_I)
			irq <= 1'b0;
		else
			irq <= next_irq;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------

	assign SYS_RST_O = core.pls_on;
	assign IRQ_O     = irq;
	assign RUNNING_O = st[1];
	assign COUNT_O   = core.count;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------

	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!NRST_I);

	sequence s_timeout_m0;
		(st == wdg_pkg::ST_RUN) && WDOG_ENABLE_BIT_I && core.zero && !kick && !RESPONSE_MODE_BIT_I;
	endsequence

	sequence s_timeout_m1;
		(st == wdg_pkg::ST_RUN) && WDOG_ENABLE_BIT_I && core.zero && !kick && RESPONSE_MODE_BIT_I;
	endsequence

	property p_count_dec;
		((st == wdg_pkg::ST_RUN) && WDOG_ENABLE_BIT_I && !kick && !core.zero)
			|=> (COUNT_O == ($past(COUNT_O) - wdg_pkg::CNT_STEP));
	endproperty
	a_count_dec: assert property (p_count_dec) else $error("counter did not step down by one");

	property p_first_load;
		((st == wdg_pkg::ST_IDLE) && WDOG_ENABLE_BIT_I && !first_done)
			|=> (COUNT_O == tmo_value($past(TIMEOUT_RANGE_INIT_I)));
	endproperty
	a_first_load: assert property (p_first_load) else $error("first load not from initial field");

	property p_later_load;
		((st == wdg_pkg::ST_IDLE) && WDOG_ENABLE_BIT_I && first_done)
			|=> (COUNT_O == tmo_value($past(TIMEOUT_RANGE_I)));
	endproperty
	a_later_load: assert property (p_later_load) else $error("later load not from regular field");

	property p_mode_reset;
		s_timeout_m0 |=> SYS_RST_O && !$rose(IRQ_O) ##1 SYS_RST_O;
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("reset mode did not reset");

	property p_mode_irq;
		s_timeout_m1 ##0 !irq |=> IRQ_O && !SYS_RST_O && (COUNT_O == tmo_value($past(TIMEOUT_RANGE_I)));
	endproperty
	a_mode_irq: assert property (p_mode_irq) else $error("interrupt mode did not raise interrupt");

	property p_escalate;
		s_timeout_m1 ##0 irq |=> SYS_RST_O && (st == wdg_pkg::ST_RST);
	endproperty
	a_escalate: assert property (p_escalate) else $error("pending interrupt did not escalate");

	property p_kick_reload;
		((st == wdg_pkg::ST_RUN) && WDOG_ENABLE_BIT_I && kick)
			|=> (COUNT_O == tmo_value($past(TIMEOUT_RANGE_I))) && !SYS_RST_O;
	endproperty
	a_kick_reload: assert property (p_kick_reload) else $error("restart did not reload counter");

	property p_kick_at_zero;
		((st == wdg_pkg::ST_RUN) && core.zero && kick) |=> !IRQ_O;
	endproperty
	a_kick_at_zero: assert property (p_kick_at_zero) else $error("interrupt raised despite restart");

	property p_read_clear;
		(IRQ_CLEAR_RD_I && !to_irq) |=> !IRQ_O;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear interrupt");

	property p_kick_clear;
		kick |=> !IRQ_O;
	endproperty
	a_kick_clear: assert property (p_kick_clear) else $error("restart did not clear interrupt");

	property p_kick_no_cancel;
		(SYS_RST_O && kick && !core.pls_last) |=> SYS_RST_O;
	endproperty
	a_kick_no_cancel: assert property (p_kick_no_cancel) else $error("restart cut the reset pulse");

	property p_bad_key;
		((st == wdg_pkg::ST_RUN) && WDOG_ENABLE_BIT_I && RESTART_WR_I && !kick && !core.zero && !IRQ_CLEAR_RD_I)
			|=> (COUNT_O == ($past(COUNT_O) - wdg_pkg::CNT_STEP)) && (IRQ_O == $past(IRQ_O));
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("wrong key changed watchdog state");

	property p_pulse_end;
		(core.pls_last && WDOG_ENABLE_BIT_I)
			|=> !SYS_RST_O && RUNNING_O && (COUNT_O == tmo_value($past(TIMEOUT_RANGE_I)));
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("counter not reloaded after reset pulse");

	property p_disable_freeze;
		((st == wdg_pkg::ST_RUN) && !WDOG_ENABLE_BIT_I)
			|=> !RUNNING_O && (COUNT_O == $past(COUNT_O));
	endproperty
	a_disable_freeze: assert property (p_disable_freeze) else $error("disable did not freeze counter");

endmodule : wdg_top

//--- wdg_pkg.sv
// shared constants and types of the watchdog timer
package wdg_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int CNT_W = 32;	// down counter width
	localparam int SEL_W = 4;	// timeout range select width
	localparam int LEN_W = 3;	// reset pulse length select width
	localparam int KEY_W = 8;	// restart key width
	localparam int PLS_W = 9;	// reset pulse cycle counter width

	// ----------------------------------------------------------------
	// values
	// ----------------------------------------------------------------
	localparam logic [KEY_W-1:0] KICK_KEY     = 8'h76;	// restart key
	localparam int               TMO_BASE_EXP = 16;	// timeout = 2^(base + sel)
	localparam logic [PLS_W-1:0] PLS_LEN_BASE = 9'h002;	// pulse = base << sel
	localparam logic [PLS_W-1:0] PLS_STEP     = 9'h001;	// pulse counter step
	localparam logic [PLS_W-1:0] PLS_RST      = 9'h000;	// pulse counter reset
	localparam logic [CNT_W-1:0] CNT_RST      = 32'h0000_0000;	// counter reset
	localparam logic [CNT_W-1:0] CNT_STEP     = 32'h0000_0001;	// counter step
	localparam logic [CNT_W-1:0] CNT_ONE      = 32'h0000_0001;	// shift seed

	// ----------------------------------------------------------------
	// control states
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_RST  = 3'b100
	} wdg_state_t;

endpackage : wdg_pkg

//--- wdg_core_if.sv
// signals between the watchdog control, its counter and its reset pulse
`timescale 1ns/10ps
interface wdg_core_if;
	logic                          load;	// load counter
	logic [wdg_pkg::CNT_W-1:0]     load_val;	// value to load
	logic                          run;	// decrement this cycle
	logic [wdg_pkg::CNT_W-1:0]     count;	// current count
	logic                          zero;	// count is zero
	logic                          pls_start;	// start reset pulse
	logic [wdg_pkg::LEN_W-1:0]     pls_sel;	// pulse length select
	logic                          pls_on;	// reset pulse active
	logic                          pls_last;	// last pulse cycle

	modport ctrl (output load, load_val, run, pls_start, pls_sel, input count, zero, pls_on, pls_last);
	modport cnt  (input load, load_val, run, output count, zero);
	modport pls  (input pls_start, pls_sel, output pls_on, pls_last);
endinterface : wdg_core_if

//--- wdg_down_cnt.sv
// 32-bit watchdog down counter
`timescale 1ns/10ps
module wdg_down_cnt (
	input  wire logic clk_i,	// bus clock
	input  wire logic nrst_i,	// async reset, active low
	wdg_core_if.cnt   core	// load and run controls
);

	logic [wdg_pkg::CNT_W-1:0] count;
	logic [wdg_pkg::CNT_W-1:0] next_count;

	// load wins over counting; the count rests at zero
	always_comb
	begin
		next_count = count;
		if (core.load)
			next_count = core.load_val;
		else if (core.run && (count != wdg_pkg::CNT_RST))
			next_count = count - wdg_pkg::CNT_STEP;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			count <= wdg_pkg::CNT_RST;
		else
			count <= next_count;
	end

	assign core.count = count;
	assign core.zero  = (count == wdg_pkg::CNT_RST);

	property p_load_takes;
		@(posedge clk_i) disable iff (!nrst_i)
		core.load |=> (count == $past(core.load_val));
	endproperty
	a_load_takes: assert property (p_load_takes) else $error("counter did not take load value");

endmodule : wdg_down_cnt

//--- wdg_rst_pulse.sv
// system reset pulse generator with eight lengths
`timescale 1ns/10ps
module wdg_rst_pulse (
	input  wire logic clk_i,	// bus clock
	input  wire logic nrst_i,	// async reset, active low
	wdg_core_if.pls   core	// start request and pulse state
);

	function automatic logic [wdg_pkg::PLS_W-1:0] pulse_len(input logic [wdg_pkg::LEN_W-1:0] sel);
		pulse_len = wdg_pkg::PLS_LEN_BASE << sel;
	endfunction : pulse_len

	logic                      rst_on;
	logic                      next_rst_on;
	logic [wdg_pkg::PLS_W-1:0] remain;
	logic [wdg_pkg::PLS_W-1:0] next_remain;
	logic [wdg_pkg::LEN_W-1:0] len_sel;
	logic [wdg_pkg::LEN_W-1:0] next_len_sel;
	logic [wdg_pkg::PLS_W-1:0] hi_len;
	logic [wdg_pkg::PLS_W-1:0] next_hi_len;

	// length is latched at start, so later select changes cannot bend a running pulse
	always_comb
	begin
		next_rst_on = rst_on;
		next_remain = remain;
		next_len_sel = len_sel;
		if (!rst_on)
		begin
			if (core.pls_start)
			begin
				next_rst_on = 1'b1;
				next_remain = pulse_len(core.pls_sel) - wdg_pkg::PLS_STEP;
				next_len_sel = core.pls_sel;
			end
		end
		else if (remain == wdg_pkg::PLS_RST)
			next_rst_on = 1'b0;
		else
			next_remain = remain - wdg_pkg::PLS_STEP;
		next_hi_len = rst_on ? (hi_len + wdg_pkg::PLS_STEP) : wdg_pkg::PLS_RST;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_on <= 1'b0;
			remain <= wdg_pkg::PLS_RST;
			len_sel <= 3'h0;
			hi_len <= wdg_pkg::PLS_RST;
		end
		else
		begin
			rst_on <= next_rst_on;
			remain <= next_remain;
			len_sel <= next_len_sel;
			hi_len <= next_hi_len;
		end
	end

	assign core.pls_on   = rst_on;
	assign core.pls_last = rst_on && (remain == wdg_pkg::PLS_RST);

	property p_pulse_len;
		@(posedge clk_i) disable iff (!nrst_i)
		$fell(rst_on) |-> (hi_len == pulse_len(len_sel));
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

endmodule : wdg_rst_pulse

//--- wdg_rst_ctl_model.sv
// reset controller model: measures the watchdog reset pulse and can cut it short
`timescale 1ns/10ps
module wdg_rst_ctl_model (
	input  wire logic       clk_i,	// bus clock
	input  wire logic       sys_rst_i,	// reset request from the watchdog
	input  wire logic       cut_en_i,	// end pulses early
	input  wire logic [9:0] cut_at_i,	// pulse cycles before cutting
	output logic            rst_req_n_o,	// device reset, active low
	output logic [9:0]      pulse_len_o	// length of the last pulse
);
	logic [9:0] run_len;	// cycles high so far
	logic [1:0] hold;	// cycles left in our own reset

	initial
	begin
		run_len = 10'h000;
		hold = 2'h0;
		rst_req_n_o = 1'b1;
		pulse_len_o = 10'h000;
	end

	always @(posedge clk_i)
	begin
		if (hold != 2'h0)
			hold <= hold - 2'h1;
		if (hold == 2'h1)
			rst_req_n_o <= 1'b1;
		if (sys_rst_i)
		begin
			run_len <= run_len + 10'h001;
			// a real controller resets the device in mid-pulse, never kinder
			if (cut_en_i && (run_len + 10'h001) == cut_at_i)
			begin
				rst_req_n_o <= 1'b0;
				hold <= 2'h2;
			end
		end
		else if (run_len != 10'h000)
		begin
			pulse_len_o <= run_len;
			run_len <= 10'h000;
		end
	end
endmodule : wdg_rst_ctl_model

//--- test_watchdog_timeout_reset.sv
// self-checking testbench of the watchdog timer
`timescale 1ns/10ps
module test_watchdog_timeout_reset;
	localparam int unsigned BASE = 2;	// short timeouts keep the run brief
	logic        clk;	// bus clock
	logic        rst_n;	// bench reset, active low
	logic        en, mode, wr, rd, cut_en;	// control strobes and levels
	logic [3:0]  init_sel, sel;	// timeout selects
	logic [2:0]  len_sel;	// pulse length select
	logic [7:0]  wdat;	// restart data
	logic [9:0]  cut_at, plen;	// cut point and measured pulse
	logic        sys_rst, irq, running, req_n;	// observed outputs
	logic [31:0] count;	// counter value
	int          fails, num_checks;	// mismatch and comparison counts
	wire         nrst = rst_n & req_n;	// bench or controller reset

	wdg_top #(.TMO_BASE_EXP(BASE)) wdg_top_i (
		.CLK_SYS_I(clk), .NRST_I(nrst), .WDOG_ENABLE_BIT_I(en), .RESPONSE_MODE_BIT_I(mode),
		.TIMEOUT_RANGE_INIT_I(init_sel), .TIMEOUT_RANGE_I(sel), .RESET_PULSE_LEN_FIELD_I(len_sel),
		.RESTART_WR_I(wr), .RESTART_DATA_I(wdat), .IRQ_CLEAR_RD_I(rd),
		.SYS_RST_O(sys_rst), .IRQ_O(irq), .RUNNING_O(running), .COUNT_O(count));

	wdg_rst_ctl_model wdg_rst_ctl_model_i (
		.clk_i(clk), .sys_rst_i(sys_rst), .cut_en_i(cut_en), .cut_at_i(cut_at),
		.rst_req_n_o(req_n), .pulse_len_o(plen));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] tmo(input logic [3:0] s);
		return 32'h0000_0001 << (BASE + s);
	endfunction : tmo

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// wait edges and sample once outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// bounded wait for the counter or the reset output to reach a value
	task automatic wait_on(input bit is_cnt, input logic [31:0] v);
		int k;
		k = 0;
		#1;
		while ((is_cnt ? count : {31'h0, sys_rst}) !== v && k < 2000)
		begin
			cyc(1);
			k++;
		end
		if (k >= 2000)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, (is_cnt ? count : {31'h0, sys_rst}), v);
		end
	endtask : wait_on

	// one restart register write
	task automatic kick(input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		wdat <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : kick

	// one read of the clear-on-read register
	task automatic clr_rd();
		@(posedge clk);
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
	endtask : clr_rd

	// reset-mode timeout with a given pulse length
	task automatic do_pulse(input logic [2:0] len, input bit mid_kick);
		@(posedge clk);
		len_sel <= len;
		wait_on(1'b1, 32'h0);
		cyc(1);
		chk(sys_rst, 1'b1);
		chk(running, 1'b0);
		if (mid_kick)
			kick(8'h76);
		wait_on(1'b0, 32'h0);
		chk(count, tmo(sel));
		cyc(1);
		chk(plen, 10'h002 << len);
	endtask : do_pulse

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// a hang counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		print_verdict();
	end

	initial
	begin
		fails = 0;
		num_checks = 0;
		rst_n = 1'b0;
		en = 1'b0;
		mode = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		wdat = 8'h00;
		init_sel = 4'h1;
		sel = 4'h0;
		len_sel = 3'h0;
		cut_en = 1'b0;
		cut_at = 10'h005;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
		chk(sys_rst, 1'b0);
		chk(count, 32'h0);
		// mode and ranges already set, then enable
		@(posedge clk);
		en <= 1'b1;
		cyc(1);
		chk(count, tmo(init_sel));
		chk(running, 1'b1);
		for (int r = 0; r < 8; r++)
			do_pulse(r[2:0], r == 3);
		kick(8'h76);
		chk(count, tmo(sel));
		kick(8'h75);
		chk(count, tmo(sel) - 32'h2);
		@(posedge clk);
		en <= 1'b0;
		len_sel <= 3'h0;
		mode <= 1'b1;
		sel <= 4'h1;
		cyc(2);
		@(posedge clk);
		en <= 1'b1;
		cyc(1);
		chk(count, tmo(sel));
		wait_on(1'b1, 32'h0);
		cyc(1);
		chk(irq, 1'b1);
		chk(sys_rst, 1'b0);
		clr_rd();
		chk(irq, 1'b0);
		wait_on(1'b1, 32'h0);
		cyc(1);
		chk(irq, 1'b1);
		kick(8'h76);
		chk(irq, 1'b0);
		wait_on(1'b1, 32'h0);
		wait_on(1'b1, 32'h1);
		wait_on(1'b1, 32'h0);
		cyc(1);
		chk(sys_rst, 1'b1);
		wait_on(1'b0, 32'h0);
		// interrupt still pending: a missed kick at zero would reset
		wait_on(1'b1, 32'h1);
		kick(8'h76);
		chk(irq, 1'b0);
		chk(sys_rst, 1'b0);
		chk(count, tmo(sel));
		@(posedge clk);
		en <= 1'b0;
		mode <= 1'b0;
		len_sel <= 3'h7;
		cut_en <= 1'b1;
		cyc(1);
		@(posedge clk);
		en <= 1'b1;
		wait_on(1'b1, 32'h0);
		cyc(1);
		wait_on(1'b0, 32'h0);
		@(posedge clk);
		en <= 1'b0;
		cyc(4);
		chk(plen, cut_at);
		chk(count, 32'h0);
		@(posedge clk);
		en <= 1'b1;
		cyc(1);
		chk(count, tmo(init_sel));
		print_verdict();
	end
endmodule : test_watchdog_timeout_reset
